// file: mfcp_defines.svh
// field positions, check constants, reset values and timing counts of the frame packer
`ifndef MFCP_DEFINES_SVH
`define MFCP_DEFINES_SVH
`define MFCP_CMD_ID_HI      31
`define MFCP_CMD_ID_LO      27
`define MFCP_CMD_WR_BIT     26
`define MFCP_CMD_REG_HI     25
`define MFCP_CMD_REG_LO     20
`define MFCP_CMD_DAT_HI     19
`define MFCP_CMD_DAT_LO     12
`define MFCP_CMD_CRC_HI     11
`define MFCP_CMD_CRC_LO     0
`define MFCP_PKT_TAG_W      6
`define MFCP_PKT_LIFE_W     3
`define MFCP_PKT_DAT_W      14
`define MFCP_PKT_DEV_W      5
`define MFCP_SEC_W          10
`define MFCP_CRC12_KOOP     12'hB41
`define MFCP_CRC16_KOOP     16'hC86C
`define MFCP_CRC12_SEED     12'h000
`define MFCP_CRC16_SEED     16'h0000
`define MFCP_CMD_STEPS_M1   5'h13
`define MFCP_PKT_STEPS_M1   6'h2F
`define MFCP_LIFE_RESET     3'h0
`define MFCP_DBG_SEL_BIT    0
`define MFCP_LINK_RATE_KBPS 3125
`define MFCP_LINK_CLK_NS    32
`define MFCP_LINK_BIT_NS    (1000000 / `MFCP_LINK_RATE_KBPS)
`define MFCP_LINK_HALF_CYC  (`MFCP_LINK_BIT_NS / (2 * `MFCP_LINK_CLK_NS))
`define MFCP_TURN_BITS      40
`endif

// file: mfcp_pkg.sv
// state types of the frame packer
package mfcp_pkg;
	typedef enum logic [1:0] {
		MFCP_CS_IDLE  = 2'b00,
		MFCP_CS_CRC   = 2'b01,
		MFCP_CS_CHECK = 2'b10
	} mfcp_cmd_state_t;
	typedef enum logic [1:0] {
		MFCP_PS_IDLE = 2'b00,
		MFCP_PS_CRC  = 2'b01,
		MFCP_PS_DONE = 2'b10
	} mfcp_pkt_state_t;
	typedef enum logic [2:0] {
		MFCP_LS_IDLE  = 3'b000,
		MFCP_LS_START = 3'b001,
		MFCP_LS_DATA  = 3'b010,
		MFCP_LS_STOP  = 3'b011,
		MFCP_LS_TURN  = 3'b100
	} mfcp_link_state_t;
endpackage : mfcp_pkg

// file: mfcp_chain_link.sv
// chain link end on the link clock: manchester framing, turnaround and debug mirror
`timescale 1ns/1ps
`include "mfcp_defines.svh"
module mfcp_chain_link
	import mfcp_pkg::*;
#(
	parameter int HALF_CYC  = `MFCP_LINK_HALF_CYC,
	parameter int TURN_BITS = `MFCP_TURN_BITS
)(
	input  wire logic        link_clk,
	input  wire logic        rstn,
	input  wire logic        tx_req,
	input  wire logic [31:0] tx_word,
	input  wire logic        tx_bidir,
	output logic             tx_ack,
	input  wire logic        is_master,
	input  wire logic        dbg_sel,
	input  wire logic        up_rx,
	input  wire logic        down_rx,
	output logic             up_tx,
	output logic             up_oe,
	output logic             gen_out_one,
	output logic             gen_out_two
);
	localparam logic [2:0] HALF_M1 = 3'(HALF_CYC - 1);
	localparam logic [6:0] TURN_M1 = 7'(TURN_BITS - 1);

	typedef struct packed {
		logic [1:0]       rst_sync;
		logic [1:0]       req_sync;
		logic [1:0]       mst_sync;
		logic [1:0]       dbg_sync;
		logic [1:0]       up_sync;
		logic [1:0]       dn_sync;
		logic             ack;
		mfcp_link_state_t st;
		logic [31:0]      sh;
		logic             bidir;
		logic [2:0]       hcnt;
		logic             half;
		logic [6:0]       bitn;
		logic             tx;
		logic             oe;
		logic             g1;
		logic             g2;
	} mfcp_link_t;

	mfcp_link_t s;
	mfcp_link_t next_s;
	logic       tick;
	logic       bit_end;

	always_comb
	begin
		next_s          = s;
		next_s.rst_sync = {s.rst_sync[0], rstn};
		next_s.req_sync = {s.req_sync[0], tx_req};
		next_s.mst_sync = {s.mst_sync[0], is_master};
		next_s.dbg_sync = {s.dbg_sync[0], dbg_sel};
		next_s.up_sync  = {s.up_sync[0], up_rx};
		next_s.dn_sync  = {s.dn_sync[0], down_rx};
		tick            = (s.hcnt == HALF_M1);
		bit_end         = tick && s.half;
		next_s.hcnt     = tick ? 3'h0 : s.hcnt + 3'h1;
		next_s.half     = tick ? ~s.half : s.half;
		case (s.st)
			MFCP_LS_IDLE:
			begin
				next_s.hcnt = 3'h0;
				next_s.half = 1'b0;
				next_s.oe   = 1'b0;
				next_s.tx   = 1'b0;
				if (s.req_sync[1] != s.ack)
				begin
					next_s.ack = s.req_sync[1];
					if (s.mst_sync[1]) // RULE_18
					begin
						next_s.sh    = tx_word;
						next_s.bidir = tx_bidir;
						next_s.bitn  = 7'h00;
						next_s.st    = MFCP_LS_START;
						next_s.oe    = 1'b1;
						next_s.tx    = 1'b1; // RULE_16
					end
				end
			end
			MFCP_LS_START:
			begin
				if (bit_end)
				begin
					next_s.st = MFCP_LS_DATA;
					next_s.tx = s.sh[31];
				end
			end
			MFCP_LS_DATA:
			begin
				if (tick && !s.half)
					next_s.tx = ~s.sh[31]; // RULE_16
				else if (bit_end)
				begin
					next_s.sh   = {s.sh[30:0], 1'b0};
					next_s.bitn = s.bitn + 7'h01;
					next_s.tx   = s.sh[30];
					if (s.bitn == 7'h1F)
					begin
						next_s.st = MFCP_LS_STOP;
						next_s.tx = 1'b0;
					end
				end
			end
			MFCP_LS_STOP:
			begin
				if (bit_end)
				begin
					next_s.oe   = 1'b0;
					next_s.bitn = 7'h00;
					next_s.st   = s.bidir ? MFCP_LS_TURN : MFCP_LS_IDLE; // RULE_17
				end
			end
			MFCP_LS_TURN:
			begin
				next_s.oe = 1'b0;
				if (bit_end)
				begin
					next_s.bitn = s.bitn + 7'h01;
					if (s.bitn == TURN_M1)
						next_s.st = MFCP_LS_IDLE;
				end
			end
			default:
				next_s.st = MFCP_LS_IDLE;
		endcase
		// master mirrors its own upward commands, a slave the ones from below
		next_s.g1 = s.dbg_sync[1] && (s.mst_sync[1] ? (s.tx && s.oe) : s.dn_sync[1]); // RULE_20
		next_s.g2 = s.dbg_sync[1] && s.up_sync[1]; // RULE_19
		if (!s.rst_sync[1])
		begin
			next_s.ack  = 1'b0;
			next_s.st   = MFCP_LS_IDLE;
			next_s.sh   = 32'h0000_0000;
			next_s.bidir = 1'b0;
			next_s.hcnt = 3'h0;
			next_s.half = 1'b0;
			next_s.bitn = 7'h00;
			next_s.tx   = 1'b0;
			next_s.oe   = 1'b0;
			next_s.g1   = 1'b0;
			next_s.g2   = 1'b0;
		end
	end

	always_ff @(posedge link_clk)
		s <= next_s;

	assign tx_ack      = s.ack;
	assign up_tx       = s.tx;
	assign up_oe       = s.oe;
	assign gen_out_one = s.g1;
	assign gen_out_two = s.g2;
endmodule : mfcp_chain_link

// file: mfcp_frame_packer.sv
// command check, result packet builder and chain link hand-off of the monitor
`timescale 1ns/1ps
`include "mfcp_defines.svh"
// Operation
// RULE_01: every result packet carries two six-bit channel tags
// RULE_02: three-bit life counter steps once per completed conversion set, sits in packets
// RULE_03: life counter wraps from 7 back to 0
// RULE_04: software reset or power-down clears the life counter
// RULE_05: primary-path results go into the data slot unchanged
// RULE_06: secondary-path results are inverted 10 bits with top 4 bits zero
// RULE_07: packet check covers bits 63 down to 16
// RULE_08: packet check generator is Koopman C86C
// RULE_09: command holds id, selector, register, data and 12-bit check
// RULE_10: packet fields are tag, life, tag, data, id, data, check
// RULE_11: command check shifts the 20 upper bits serially, highest first
// RULE_12: packet check shifts the 48 upper bits serially, 63 to 16
// RULE_13: check registers start from zero
// RULE_14: 12-bit step feeds back into stages 0, 1, 7, 9, 10
// RULE_15: 16-bit step feeds back into stages 0, 3, 4, 6, 7, 12, 15
// RULE_16: chain frame is start, manchester payload with check, stop
// RULE_17: link is one-way for writes, turns around for reads
// RULE_18: only the master takes host commands and drives the chain
// RULE_19: debug select bit 0 mirrors chain traffic on both general outputs
// RULE_20: output one shows commands, output two shows data from above
// RULE_21: command check generator is Koopman B41
// RULE_22: commands with a wrong check are discarded
// RULE_23: selector high means one-way exchange, low means two-way
// RULE_24: final check register lands in the field, top stage in msb
module mfcp_frame_packer
	import mfcp_pkg::*;
#(
	parameter int HALF_CYC  = `MFCP_LINK_HALF_CYC,
	parameter int TURN_BITS = `MFCP_TURN_BITS
)(
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic        link_clk,
	input  wire logic        is_master,
	input  wire logic [7:0]  output_control_reg,
	input  wire logic        cmd_valid,
	input  wire logic [31:0] cmd_word,
	output logic             cmd_ready,
	output logic             cmd_exec_valid,
	output logic [4:0]       cmd_exec_dev,
	output logic             cmd_exec_write,
	output logic [5:0]       cmd_exec_reg,
	output logic [7:0]       cmd_exec_data,
	output logic             cmd_discard,
	input  wire logic        seq_done,
	input  wire logic        soft_reset,
	input  wire logic        power_down,
	input  wire logic        res_valid,
	input  wire logic [5:0]  res_tag_one,
	input  wire logic [5:0]  res_tag_two,
	input  wire logic [13:0] res_data_one,
	input  wire logic [13:0] res_data_two,
	input  wire logic        res_secondary,
	input  wire logic [4:0]  device_id,
	output logic             res_ready,
	output logic             pkt_valid,
	output logic [63:0]      pkt_word,
	output logic [2:0]       life_count,
	input  wire logic        up_rx,
	input  wire logic        chain_down_pair,
	output logic             up_tx,
	output logic             up_oe,
	output logic             gen_out_one,
	output logic             gen_out_two
);
	localparam logic [11:0] CRC12_MASK = 12'({`MFCP_CRC12_KOOP, 1'b1}); // RULE_21
	localparam logic [15:0] CRC16_MASK = 16'({`MFCP_CRC16_KOOP, 1'b1}); // RULE_08

	typedef struct packed {
		mfcp_cmd_state_t cst;
		logic [31:0]     cmd;
		logic [19:0]     cshift;
		logic [11:0]     c12;
		logic [4:0]      cstep;
		logic            crdy;
		logic            exec_valid;
		logic            discard;
		mfcp_pkt_state_t pst;
		logic [47:0]     pkt_hi;
		logic [47:0]     pshift;
		logic [15:0]     c16;
		logic [5:0]      pstep;
		logic            prdy;
		logic            pvalid;
		logic [63:0]     pkt;
		logic [2:0]      life;
		logic [31:0]     tx_word;
		logic            tx_bidir;
		logic            tx_req;
		logic [1:0]      ack_sync;
	} mfcp_sys_t;

	mfcp_sys_t s;
	mfcp_sys_t next_s;
	logic      link_ack;
	logic      link_busy;

	// one serial step; feedback enters stage 0 and every tapped stage
	function automatic logic [11:0] crc12_step(input logic [11:0] crc, input logic din);
		logic fb;
		fb = din ^ crc[11];
		crc12_step = {crc[10:0], 1'b0} ^ (fb ? CRC12_MASK : 12'h000); // RULE_14
	endfunction : crc12_step

	function automatic logic [15:0] crc16_step(input logic [15:0] crc, input logic din);
		logic fb;
		fb = din ^ crc[15];
		crc16_step = {crc[14:0], 1'b0} ^ (fb ? CRC16_MASK : 16'h0000); // RULE_15
	endfunction : crc16_step

	function automatic logic [13:0] fmt_result(input logic [13:0] raw, input logic sec);
		if (sec)
			fmt_result = {4'h0, ~raw[`MFCP_SEC_W-1:0]}; // RULE_06
		else
			fmt_result = raw; // RULE_05
	endfunction : fmt_result

	assign link_busy = (s.tx_req != s.ack_sync[1]);

	always_comb
	begin
		next_s            = s;
		next_s.exec_valid = 1'b0;
		next_s.discard    = 1'b0;
		next_s.pvalid     = 1'b0;
		next_s.ack_sync   = {s.ack_sync[0], link_ack};

		case (s.cst)
			MFCP_CS_IDLE:
			begin
				next_s.crdy = 1'b1;
				if (cmd_valid && s.crdy && is_master) // RULE_18
				begin
					next_s.cmd    = cmd_word;
					next_s.cshift = cmd_word[`MFCP_CMD_ID_HI:`MFCP_CMD_DAT_LO]; // RULE_09
					next_s.c12    = `MFCP_CRC12_SEED; // RULE_13
					next_s.cstep  = 5'h00;
					next_s.crdy   = 1'b0;
					next_s.cst    = MFCP_CS_CRC;
				end
			end
			MFCP_CS_CRC:
			begin
				next_s.c12    = crc12_step(s.c12, s.cshift[19]); // RULE_11
				next_s.cshift = {s.cshift[18:0], 1'b0};
				next_s.cstep  = s.cstep + 5'h01;
				if (s.cstep == `MFCP_CMD_STEPS_M1)
					next_s.cst = MFCP_CS_CHECK;
			end
			MFCP_CS_CHECK:
			begin
				// c12[11] is compared against field bit 11
				if (s.c12 != s.cmd[`MFCP_CMD_CRC_HI:`MFCP_CMD_CRC_LO]) // RULE_24
				begin
					next_s.discard = 1'b1; // RULE_22
					next_s.cst     = MFCP_CS_IDLE;
					next_s.crdy    = 1'b1;
				end
				else if (!link_busy)
				begin
					next_s.exec_valid = 1'b1;
					next_s.tx_word    = s.cmd;
					next_s.tx_bidir   = ~s.cmd[`MFCP_CMD_WR_BIT]; // RULE_23
					next_s.tx_req     = ~s.tx_req;
					next_s.cst        = MFCP_CS_IDLE;
					next_s.crdy       = 1'b1;
				end
			end
			default:
			begin
				next_s.cst  = MFCP_CS_IDLE;
				next_s.crdy = 1'b1;
			end
		endcase

		case (s.pst)
			MFCP_PS_IDLE:
			begin
				next_s.prdy = 1'b1;
				if (res_valid && s.prdy)
				begin
					next_s.pkt_hi = {res_tag_one, s.life, res_tag_two, // RULE_01
						fmt_result(res_data_one, res_secondary), device_id,
						fmt_result(res_data_two, res_secondary)}; // RULE_10
					next_s.pshift = next_s.pkt_hi;
					next_s.c16    = `MFCP_CRC16_SEED; // RULE_13
					next_s.pstep  = 6'h00;
					next_s.prdy   = 1'b0;
					next_s.pst    = MFCP_PS_CRC;
				end
			end
			MFCP_PS_CRC:
			begin
				next_s.c16    = crc16_step(s.c16, s.pshift[47]); // RULE_12
				next_s.pshift = {s.pshift[46:0], 1'b0};
				next_s.pstep  = s.pstep + 6'h01;
				if (s.pstep == `MFCP_PKT_STEPS_M1)
					next_s.pst = MFCP_PS_DONE;
			end
			MFCP_PS_DONE:
			begin
				next_s.pkt    = {s.pkt_hi, s.c16}; // RULE_07
				next_s.pvalid = 1'b1;
				next_s.prdy   = 1'b1;
				next_s.pst    = MFCP_PS_IDLE;
			end
			default:
			begin
				next_s.pst  = MFCP_PS_IDLE;
				next_s.prdy = 1'b1;
			end
		endcase

		if (soft_reset || power_down)
			next_s.life = `MFCP_LIFE_RESET; // RULE_04
		else if (seq_done)
			next_s.life = s.life + 3'h1; // RULE_02 RULE_03

		if (!rstn)
		begin
			next_s.cst        = MFCP_CS_IDLE;
			next_s.cmd        = 32'h0000_0000;
			next_s.cshift     = 20'h0_0000;
			next_s.c12        = `MFCP_CRC12_SEED;
			next_s.cstep      = 5'h00;
			next_s.crdy       = 1'b0;
			next_s.exec_valid = 1'b0;
			next_s.discard    = 1'b0;
			next_s.pst        = MFCP_PS_IDLE;
			next_s.pkt_hi     = 48'h0000_0000_0000;
			next_s.pshift     = 48'h0000_0000_0000;
			next_s.c16        = `MFCP_CRC16_SEED;
			next_s.pstep      = 6'h00;
			next_s.prdy       = 1'b0;
			next_s.pvalid     = 1'b0;
			next_s.pkt        = 64'h0000_0000_0000_0000;
			next_s.life       = `MFCP_LIFE_RESET; // RULE_04
			next_s.tx_word    = 32'h0000_0000;
			next_s.tx_bidir   = 1'b0;
			next_s.tx_req     = 1'b0;
			next_s.ack_sync   = 2'h0;
		end
	end

	always_ff @(posedge clk_sys)
		s <= next_s;

	// commands leave through a toggle handshake; the word holds until acknowledged
	mfcp_chain_link #(
		.HALF_CYC  (HALF_CYC),
		.TURN_BITS (TURN_BITS)
	) u_link (
		.link_clk    (link_clk),
		.rstn        (rstn),
		.tx_req      (s.tx_req),
		.tx_word     (s.tx_word),
		.tx_bidir    (s.tx_bidir),
		.tx_ack      (link_ack),
		.is_master   (is_master),
		.dbg_sel     (output_control_reg[`MFCP_DBG_SEL_BIT]), // RULE_19
		.up_rx       (up_rx),
		.down_rx     (chain_down_pair),
		.up_tx       (up_tx), // RULE_16
		.up_oe       (up_oe), // RULE_17
		.gen_out_one (gen_out_one), // RULE_20
		.gen_out_two (gen_out_two)
	);

	assign cmd_ready      = s.crdy;
	assign cmd_exec_valid = s.exec_valid;
	assign cmd_exec_dev   = s.cmd[`MFCP_CMD_ID_HI:`MFCP_CMD_ID_LO];
	assign cmd_exec_write = s.cmd[`MFCP_CMD_WR_BIT];
	assign cmd_exec_reg   = s.cmd[`MFCP_CMD_REG_HI:`MFCP_CMD_REG_LO];
	assign cmd_exec_data  = s.cmd[`MFCP_CMD_DAT_HI:`MFCP_CMD_DAT_LO];
	assign cmd_discard    = s.discard;
	assign res_ready      = s.prdy;
	assign pkt_valid      = s.pvalid;
	assign pkt_word       = s.pkt;
	assign life_count     = s.life;
endmodule : mfcp_frame_packer

// file: mfcp_frame_packer_asserts.sv
// port checks of the frame packer
`timescale 1ns/1ps
module mfcp_frame_packer_asserts
(
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        link_clk,
	input wire logic        is_master,
	input wire logic [7:0]  output_control_reg,
	input wire logic        cmd_valid,
	input wire logic        cmd_ready,
	input wire logic        cmd_exec_valid,
	input wire logic        cmd_discard,
	input wire logic        seq_done,
	input wire logic        soft_reset,
	input wire logic        power_down,
	input wire logic        res_valid,
	input wire logic        res_secondary,
	input wire logic        res_ready,
	input wire logic        pkt_valid,
	input wire logic [63:0] pkt_word,
	input wire logic [2:0]  life_count,
	input wire logic        up_tx,
	input wire logic        up_oe,
	input wire logic        gen_out_one,
	input wire logic        gen_out_two,
	input wire logic        up_rx,
	input wire logic        chain_down_pair
);
	property p_cmd_busy;
		@(posedge clk_sys) disable iff (!rstn)
		cmd_valid && cmd_ready && is_master |=> !cmd_ready [*8];
	endproperty
	a_cmd_busy: assert property (p_cmd_busy) else $error("engine free too early");
	property p_pkt_lat;
		@(posedge clk_sys) disable iff (!rstn) res_valid && res_ready |-> ##50 pkt_valid;
	endproperty
	a_pkt_lat: assert property (p_pkt_lat) else $error("packet late");
	property p_pkt_life;
		@(posedge clk_sys) disable iff (!rstn)
		pkt_valid |-> pkt_word[57:55] == $past(life_count, 50);
	endproperty
	a_pkt_life: assert property (p_pkt_life) else $error("packet counter wrong");
	property p_life_step;
		@(posedge clk_sys) disable iff (!rstn) seq_done && !soft_reset && !power_down
		|=> life_count == 3'($past(life_count) + 3'h1);
	endproperty
	a_life_step: assert property (p_life_step) else $error("counter step wrong");
	property p_life_clr;
		@(posedge clk_sys) disable iff (!rstn) soft_reset || power_down |=> life_count == 3'h0;
	endproperty
	a_life_clr: assert property (p_life_clr) else $error("counter not cleared");
	property p_life_hold;
		@(posedge clk_sys) disable iff (!rstn)
		!seq_done && !soft_reset && !power_down |=> $stable(life_count);
	endproperty
	a_life_hold: assert property (p_life_hold) else $error("counter moved");
	property p_sec_zero;
		@(posedge clk_sys) disable iff (!rstn)
		pkt_valid && $past(res_secondary && res_valid && res_ready, 50)
		|-> pkt_word[48:45] == 4'h0 && pkt_word[29:26] == 4'h0;
	endproperty
	a_sec_zero: assert property (p_sec_zero) else $error("secondary top bits set");
	property p_one_answer;
		@(posedge clk_sys) disable iff (!rstn) cmd_discard |-> !cmd_exec_valid && cmd_ready;
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("discard and execute");
	property p_dbg_off;
		@(posedge link_clk) disable iff (!rstn)
		!output_control_reg[0] [*5] |-> !gen_out_one && !gen_out_two;
	endproperty
	a_dbg_off: assert property (p_dbg_off) else $error("mirror active while off");
	property p_frame_start;
		@(posedge link_clk) disable iff (!rstn) $rose(up_oe) |-> up_tx;
	endproperty
	a_frame_start: assert property (p_frame_start) else $error("no start level");
	property p_dbg_master;
		@(posedge link_clk) disable iff (!rstn)
		(rstn && output_control_reg[0] && is_master) [*4] |-> gen_out_one == $past(up_tx && up_oe);
	endproperty
	a_dbg_master: assert property (p_dbg_master) else $error("master mirror wrong");
	property p_dbg_slave;
		@(posedge link_clk) disable iff (!rstn)
		(rstn && output_control_reg[0] && !is_master) [*4]
		|-> gen_out_one == $past(chain_down_pair, 3);
	endproperty
	a_dbg_slave: assert property (p_dbg_slave) else $error("slave mirror wrong");
	property p_dbg_data;
		@(posedge link_clk) disable iff (!rstn)
		(rstn && output_control_reg[0]) [*4] |-> gen_out_two == $past(up_rx, 3);
	endproperty
	a_dbg_data: assert property (p_dbg_data) else $error("data mirror wrong");
endmodule : mfcp_frame_packer_asserts

bind mfcp_frame_packer mfcp_frame_packer_asserts mfcp_frame_packer_asserts_inst (
	.clk_sys, .rstn, .link_clk, .is_master, .output_control_reg, .cmd_valid, .cmd_ready,
	.cmd_exec_valid, .cmd_discard, .seq_done, .soft_reset, .power_down, .res_valid,
	.res_secondary, .res_ready, .pkt_valid, .pkt_word, .life_count, .up_tx, .up_oe,
	.gen_out_one, .gen_out_two, .up_rx, .chain_down_pair);

// file: mfcp_chain_peer.sv
// neighbour above on the chain: listens while driven, replies otherwise
`timescale 1ns/1ps
module mfcp_chain_peer
(
	input  wire logic        link_clk,
	input  wire logic        up_tx,
	input  wire logic        up_oe,
	output logic             up_rx,
	output logic [31:0]      frame_word,
	output logic [7:0]       frame_cnt,
	output logic             frame_bad
);
	logic [7:0]  pat = 8'hA5;
	logic        oe_d = 1'b0;
	logic [31:0] sh = 32'h0000_0000;
	logic [31:0] last = 32'h0000_0000;
	logic [7:0]  n_done = 8'h00;
	logic        bad = 1'b0;
	int          cnt = 0;
	always_ff @(posedge link_clk)
		pat <= {pat[6:0], pat[7] ^ pat[5] ^ pat[0]};
	// frame decoder for the default bit time of 10 link cycles; cnt counts from the first driven sample
	always_ff @(posedge link_clk)
	begin
		oe_d <= up_oe;
		if (up_oe && !oe_d)
			cnt <= 1;
		else if (up_oe)
		begin
			cnt <= cnt + 1;
			if (cnt % 10 == 2 && cnt >= 12 && cnt <= 322)
				sh <= {sh[30:0], up_tx};
			if (cnt % 10 == 7 && cnt >= 17 && cnt <= 327 && up_tx == sh[0])
				bad <= 1'b1;
			if ((cnt == 2 || cnt == 7) && !up_tx)
				bad <= 1'b1;
			if ((cnt == 332 || cnt == 337) && up_tx)
				bad <= 1'b1;
		end
		else if (oe_d)
		begin
			last   <= sh;
			n_done <= n_done + 8'h01;
			if (cnt != 340)
				bad <= 1'b1;
		end
	end
	// half-duplex: reply pattern only while the lower end is not driving
	assign up_rx      = up_oe ? up_tx : pat[0];
	assign frame_word = last;
	assign frame_cnt  = n_done;
	assign frame_bad  = bad;
endmodule : mfcp_chain_peer

// file: test_mfcp_frame_packer.sv
// self-checking bench of the frame packer
`timescale 1ns/1ps
module test_mfcp_frame_packer;
	logic        clk_sys, link_clk, rstn, is_master, cmd_valid, cmd_ready, cmd_exec_valid;
	logic        cmd_exec_write, cmd_discard, seq_done, soft_reset, power_down, res_valid;
	logic        res_secondary, res_ready, pkt_valid, up_rx, chain_down_pair, up_tx, up_oe;
	logic        gen_out_one, gen_out_two;
	logic [7:0]  output_control_reg, cmd_exec_data;
	logic [31:0] cmd_word, w;
	logic [4:0]  cmd_exec_dev, device_id;
	logic [5:0]  cmd_exec_reg, res_tag_one, res_tag_two;
	logic [13:0] res_data_one, res_data_two;
	logic [63:0] pkt_word;
	logic [2:0]  life_count;
	int          n_mismatch, total_checks, life, n_frame;
	logic [31:0] sent_q[$], frame_word;
	logic [7:0]  frame_cnt;
	logic        frame_bad;
	mfcp_frame_packer #(.TURN_BITS(4)) mfcp_frame_packer_inst (
		.clk_sys, .rstn, .link_clk, .is_master, .output_control_reg, .cmd_valid, .cmd_word,
		.cmd_ready, .cmd_exec_valid, .cmd_exec_dev, .cmd_exec_write, .cmd_exec_reg,
		.cmd_exec_data, .cmd_discard, .seq_done, .soft_reset, .power_down, .res_valid,
		.res_tag_one, .res_tag_two, .res_data_one, .res_data_two, .res_secondary,
		.device_id, .res_ready, .pkt_valid, .pkt_word, .life_count, .up_rx,
		.chain_down_pair, .up_tx, .up_oe, .gen_out_one, .gen_out_two);
	mfcp_chain_peer mfcp_chain_peer_inst (.link_clk, .up_tx, .up_oe, .up_rx, .frame_word,
		.frame_cnt, .frame_bad);
	initial
	begin
		clk_sys = 0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial
	begin
		link_clk = 0;
		#3;
		forever #16 link_clk = ~link_clk;
	end
	// serial check register with feedback mask m over the n low bits of d
	function automatic logic [15:0] crc(input logic [47:0] d, input int n, input int wd,
		input logic [15:0] m);
		logic [15:0] s;
		logic        f;
		s = 16'h0000;
		for (int i = n - 1; i >= 0; i--)
		begin
			f = d[i] ^ s[wd-1];
			s = (s << 1) ^ (f ? m : 16'h0000);
		end
		return (wd == 12) ? (s & 16'h0FFF) : s;
	endfunction : crc
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic chk_cmd(input logic [63:0] g, input logic [63:0] e);
		chk(g, e);
	endtask : chk_cmd
	task automatic chk_pkt(input logic [63:0] g, input logic [63:0] e);
		chk(g, e);
	endtask : chk_pkt
	task automatic chk_life(input logic [63:0] g, input logic [63:0] e);
		chk(g, e);
	endtask : chk_life
	task automatic chk_frame(input logic [63:0] g, input logic [63:0] e);
		chk(g, e);
	endtask : chk_frame
	task automatic tick;
		@(posedge clk_sys);
		#1;
		chain_down_pair = 1'($urandom);
		// each frame the neighbour decodes is matched against the oldest passed command
		if (frame_cnt != 8'(n_frame))
		begin
			n_frame++;
			chk_frame(64'(sent_q.size() > 0), 64'h1);
			if (sent_q.size() > 0)
				chk_frame(64'({frame_bad, frame_word}), 64'({1'b0, sent_q.pop_front()}));
		end
	endtask : tick
	function automatic logic sig(input int k);
		logic [3:0] v;
		v = {res_ready, pkt_valid, cmd_exec_valid | cmd_discard, cmd_ready};
		return v[k];
	endfunction : sig
	task automatic await(input int k);
		int n;
		n = 0;
		while (sig(k) !== 1'b1)
		begin
			tick;
			n++;
			if (n > 4000)
			begin
				n_mismatch++;
				end_sim;
			end
		end
	endtask : await
	task automatic send_cmd(input logic [31:0] c, input bit ok);
		await(0);
		cmd_word = c;
		cmd_valid = 1;
		tick;
		cmd_valid = 0;
		await(1);
		chk_cmd(64'(cmd_discard), 64'(!ok));
		if (ok)
		begin
			chk_cmd(64'({cmd_exec_dev, cmd_exec_write, cmd_exec_reg, cmd_exec_data}), 64'(c[31:12]));
			sent_q.push_back(c);
		end
	endtask : send_cmd
	task automatic send_res(input bit sec);
		logic [13:0] x, y;
		logic [47:0] h;
		await(3);
		{res_tag_one, res_tag_two, device_id} = 17'($urandom);
		{res_data_one, res_data_two} = 28'($urandom);
		res_secondary = sec;
		res_valid = 1;
		tick;
		res_valid = 0;
		x = sec ? {4'h0, ~res_data_one[9:0]} : res_data_one;
		y = sec ? {4'h0, ~res_data_two[9:0]} : res_data_two;
		h = {res_tag_one, 3'(life), res_tag_two, x, device_id, y};
		await(2);
		chk_pkt(pkt_word, {h, crc(h, 48, 16, 16'h90D9)});
	endtask : send_res
	initial
	begin
		{rstn, cmd_valid, seq_done, soft_reset, power_down, res_valid, res_secondary} = 7'h00;
		{cmd_word, res_tag_one, res_tag_two, res_data_one, res_data_two, device_id} = 77'h0;
		{n_mismatch, total_checks, life, n_frame, chain_down_pair} = 0;
		is_master = 1;
		output_control_reg = 8'h01;
		void'($urandom(81));
		repeat (16) tick;
		rstn = 1;
		tick;
		tick;
		for (int i = 0; i < 6; i++)
		begin
			w[31:12] = 20'($urandom);
			w[26] = i[0];
			w[11:0] = 12'(crc(48'(w[31:12]), 20, 12, 16'h0683));
			if (i == 5)
				w[3] = ~w[3];
			send_cmd(w, i != 5);
		end
		is_master = 0;
		cmd_valid = 1;
		repeat (40)
		begin
			tick;
			chk_cmd(64'(cmd_exec_valid), 64'h0);
		end
		cmd_valid = 0;
		is_master = 1;
		output_control_reg = 8'h00;
		for (int i = 0; i < 20; i++)
		begin
			send_res(i[0]);
			seq_done = 1;
			soft_reset = (i == 12);
			power_down = (i == 16);
			tick;
			{seq_done, soft_reset, power_down} = 3'h0;
			life = (i == 12 || i == 16) ? 0 : (life + 1) % 8;
			chk_life(64'(life_count), 64'(life));
		end
		for (int n = 0; n < 8000 && sent_q.size() > 0; n++)
			tick;
		chk_frame(64'(sent_q.size()), 64'h0);
		end_sim;
	end
endmodule : test_mfcp_frame_packer
